// file: src/qlwc_cmd.sv
`timescale 1ns/1ps
`default_nettype none
module qlwc_cmd
   import qlwc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // Host taskfile
   input  wire logic        tf_valid,
   input  var  qlwc_tf_s    tf,
   output logic             tf_ready,
   // Decoded request to log engine
   output logic             req_valid,
   output qlwc_req_s        req,
   // Completion from log engine
   input  wire logic        done_valid,
   input  var  qlwc_done_s  done,
   // Frame to host
   output logic             fr_valid,
   output qlwc_frame_e      fr_kind,
   output logic [31:0]      fr_act,
   output logic [4:0]       fr_tag,
   input  wire logic        fr_ready,
   // Register views
   output logic [7:0]       command_error_flags,
   output logic [7:0]       command_status_flags
);

   qlwc_state_e state_reg, state_next;
   logic [31:0] act_reg, act_next;
   logic [4:0]  tag_reg;
   logic [7:0]  err_reg, err_next;
   logic [7:0]  st_reg, st_next;
   logic        req_valid_reg;
   qlwc_req_s   req_reg;
   logic        fr_valid_reg;
   qlwc_frame_e fr_kind_reg;
   logic [31:0] fr_act_reg;
   logic [4:0]  fr_tag_reg;

   // Decode
   wire logic       is_send;
   wire logic [4:0] sub_code;
   wire logic       is_logwr;
   wire logic       dev_ok;
   wire logic       accept;
   wire logic       reject;
   wire logic [4:0] tf_tag;
   wire logic       done_err;
   wire logic [31:0] done_bit;
   wire logic       idle;
   wire logic       fr_take;

   assign is_send  = (tf.command == QLWC_OPC_SEND);
   assign sub_code = tf.feat_cur[QLWC_SUB_LSB +: 5];
   assign is_logwr = (sub_code == QLWC_SUB_LOGWR);
   assign dev_ok   = tf.dev_head[QLWC_DEV_LBA] & ~tf.dev_head[QLWC_DEV_ZERO];
   assign tf_tag   = tf.count_cur[QLWC_TAG_LSB +: 5];
   assign idle     = (state_reg == QLWC_ST_IDLE);
   assign tf_ready = idle;
   assign accept   = tf_valid & idle & is_send & is_logwr & dev_ok;
   // reserved subcommand or bad device byte aborts
   assign reject   = tf_valid & idle & ~(is_send & is_logwr & dev_ok);
   assign done_err = done.crc | done.unc | done.idn | done.abt;
   assign done_bit = 32'h0000_0001 << done.tag;
   assign fr_take  = fr_valid_reg & fr_ready;

   // accumulate completed tags; new completion beats clear
   always_comb begin
      act_next = act_reg;
      // Clear only the tags already reported
      if (state_reg == QLWC_ST_SDB && fr_take) begin
         act_next = act_reg & ~fr_act_reg;
      end
      if (done_valid && !done_err) begin
         act_next = act_next | done_bit;
      end
   end

   // only CRC, UNC, IDN, ABT may be set
   always_comb begin
      err_next = err_reg;
      st_next  = st_reg;
      if (reject) begin
         err_next = 8'h00;
         err_next[QLWC_ERR_ABT] = 1'b1;
      end else if (done_valid && done_err) begin
         err_next = 8'h00;
         err_next[QLWC_ERR_CRC] = done.crc;
         err_next[QLWC_ERR_UNC] = done.unc;
         err_next[QLWC_ERR_IDN] = done.idn;
         err_next[QLWC_ERR_ABT] = done.abt;
      end else if (done_valid || accept) begin
         err_next = 8'h00;
      end
      // status with RDY and ERR only
      st_next[QLWC_ST_RDY] = 1'b1;
      st_next[QLWC_ST_ERR] = (err_next != 8'h00);
      st_next = st_next & QLWC_ST_MASK;
      err_next = err_next & QLWC_ERR_MASK;
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         QLWC_ST_IDLE: begin
            // error before acknowledge goes as D2H
            if (reject || (done_valid && done_err)) begin
               state_next = QLWC_ST_D2H;
            end else if (act_next != QLWC_ACT_RST) begin
               state_next = QLWC_ST_SDB;
            end
         end
         QLWC_ST_SDB: begin
            if (fr_take) begin
               state_next = QLWC_ST_IDLE;
            end
         end
         QLWC_ST_D2H: begin
            if (fr_take) begin
               state_next = QLWC_ST_IDLE;
            end
         end
         default: state_next = QLWC_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= QLWC_ST_IDLE;
         act_reg   <= QLWC_ACT_RST;
         err_reg   <= QLWC_ERR_RST;
         st_reg    <= QLWC_ST_RST;
         tag_reg   <= 5'h00;
      end else begin
         state_reg <= state_next;
         act_reg   <= act_next;
         err_reg   <= err_next;
         st_reg    <= st_next;
         if (reject) begin
            tag_reg <= tf_tag;
         end else if (done_valid && done_err && idle) begin
            tag_reg <= done.tag;
         end
      end
   end

   // Request register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         req_valid_reg <= 1'b0;
         req_reg       <= '0;
      end else begin
         req_valid_reg <= accept;
         if (accept) begin
            req_reg.tag   <= tf_tag;
            req_reg.count <= {tf.feat_prev, tf.feat_cur};
            req_reg.addr  <= {tf.lba_hi_prev, tf.lba_mid_prev, tf.lba_lo_prev,
                              tf.lba_hi_cur, tf.lba_mid_cur, tf.lba_lo_cur};
         end
      end
   end

   // Frame output register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         fr_valid_reg <= 1'b0;
         fr_kind_reg  <= QLWC_FR_SDB;
         fr_act_reg   <= QLWC_ACT_RST;
         fr_tag_reg   <= 5'h00;
      end else if (fr_take) begin
         fr_valid_reg <= 1'b0;
      end else if (!fr_valid_reg && state_reg == QLWC_ST_SDB) begin
         fr_valid_reg <= 1'b1;
         fr_kind_reg  <= QLWC_FR_SDB;
         fr_act_reg   <= act_reg;
      end else if (!fr_valid_reg && state_reg == QLWC_ST_D2H) begin
         fr_valid_reg <= 1'b1;
         fr_kind_reg  <= QLWC_FR_D2H;
         fr_tag_reg   <= tag_reg;
      end
   end

   assign req_valid            = req_valid_reg;
   assign req                  = req_reg;
   assign fr_valid             = fr_valid_reg;
   assign fr_kind              = fr_kind_reg;
   assign fr_act               = fr_act_reg;
   assign fr_tag               = fr_tag_reg;
   assign command_error_flags  = err_reg;
   assign command_status_flags = st_reg;

   // Assertions
   // accepted command yields request
   a_accept_to_req: assert property (@(posedge clk_sys) disable iff (!arst_n)
      accept |=> req_valid)
      else $error("accepted command gave no request");
   a_reserved_abort: assert property (@(posedge clk_sys) disable iff (!arst_n)
      reject |=> command_error_flags[QLWC_ERR_ABT] && command_status_flags[QLWC_ST_ERR])
      else $error("reserved subcommand not aborted");
   a_no_req_resv: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (tf_valid && tf_ready && !is_logwr) |=> !req_valid)
      else $error("request for reserved subcommand");
   a_busy_refused: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (tf_valid && !tf_ready) |=> !req_valid)
      else $error("request while busy");
   a_err_zero_bits: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (command_error_flags & ~QLWC_ERR_MASK) == 8'h00)
      else $error("reserved error bit set");
   a_err_from_done: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (done_valid && done_err && !reject)
      |=> command_error_flags
          == $past({done.crc, done.unc, 1'b0, done.idn, 1'b0, done.abt, 2'b00}))
      else $error("error flags do not follow completion");
   a_status_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (command_status_flags & ~QLWC_ST_MASK) == 8'h00)
      else $error("BSY DF or DRQ set");
   a_status_err: assert property (@(posedge clk_sys) disable iff (!arst_n)
      command_status_flags[QLWC_ST_ERR] == (command_error_flags != 8'h00))
      else $error("ERR status disagrees with error flags");
   a_status_rdy: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $past(arst_n) |-> command_status_flags[QLWC_ST_RDY])
      else $error("RDY status low while running");
   a_req_fields: assert property (@(posedge clk_sys) disable iff (!arst_n)
      accept |=> req.count == $past({tf.feat_prev, tf.feat_cur})
                 && req.addr[31:24] == $past(tf.lba_lo_prev))
      else $error("request fields wrong");
   a_req_tag: assert property (@(posedge clk_sys) disable iff (!arst_n)
      accept |=> req.tag == $past(tf.count_cur[7:3]))
      else $error("tag wrong");
   // completed tag appears in SDB frame
   a_sdb_act: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (fr_valid && fr_kind == QLWC_FR_SDB) |-> fr_act != QLWC_ACT_RST)
      else $error("empty SDB frame");
   a_sdb_after_done: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (done_valid && !done_err && idle && !reject)
      |-> ##2 (fr_valid && fr_kind == QLWC_FR_SDB && fr_act[$past(done.tag, 2)]))
      else $error("completion missing from SDB frame");
   a_act_no_loss: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (state_reg == QLWC_ST_SDB && fr_take)
      |=> ((act_reg & $past(act_reg & ~fr_act_reg)) == $past(act_reg & ~fr_act_reg)))
      else $error("completed tag dropped from ACT");
   a_frame_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (fr_valid && !fr_ready)
      |=> (fr_valid && $stable(fr_kind) && $stable(fr_act) && $stable(fr_tag)))
      else $error("frame changed before taken");
   a_err_d2h: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (reject) |-> ##2 (fr_valid && fr_kind == QLWC_FR_D2H))
      else $error("error gave no D2H frame");
   a_d2h_after_err: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (done_valid && done_err && idle && !reject)
      |-> ##2 (fr_valid && fr_kind == QLWC_FR_D2H && fr_tag == $past(done.tag, 2)))
      else $error("engine error gave no D2H frame");

   // Scenario covers
   c_accept: cover property (@(posedge clk_sys) disable iff (!arst_n) accept);
   c_reject: cover property (@(posedge clk_sys) disable iff (!arst_n) reject);
   c_sdb: cover property (@(posedge clk_sys) disable iff (!arst_n)
      fr_take && fr_kind == QLWC_FR_SDB);
   c_d2h: cover property (@(posedge clk_sys) disable iff (!arst_n)
      fr_take && fr_kind == QLWC_FR_D2H);
   c_act_merge: cover property (@(posedge clk_sys) disable iff (!arst_n)
      fr_take && done_valid && !done_err);

endmodule : qlwc_cmd
`default_nettype wire

// file: src/qlwc_pkg.sv
package qlwc_pkg;

   // Opcode and subcommand codes
   localparam logic [7:0] QLWC_OPC_SEND   = 8'h64;
   localparam logic [4:0] QLWC_SUB_LOGWR  = 5'h02;
   localparam int         QLWC_SUB_LSB    = 0;
   localparam int         QLWC_TAG_LSB    = 3;
   localparam int         QLWC_DEV_LBA    = 6;
   localparam int         QLWC_DEV_ZERO   = 4;

   // Error register bit positions
   localparam int QLWC_ERR_CRC = 7;
   localparam int QLWC_ERR_UNC = 6;
   localparam int QLWC_ERR_IDN = 4;
   localparam int QLWC_ERR_ABT = 2;
   localparam logic [7:0] QLWC_ERR_MASK = 8'hd4;

   // Status register bit positions
   localparam int QLWC_ST_RDY = 6;
   localparam int QLWC_ST_ERR = 0;
   localparam logic [7:0] QLWC_ST_MASK = 8'h41;

   // Reset values
   localparam logic [7:0]  QLWC_ERR_RST  = 8'h00;
   localparam logic [7:0]  QLWC_ST_RST   = 8'h00;
   localparam logic [31:0] QLWC_ACT_RST  = 32'h0000_0000;

   // Taskfile as written by the host
   typedef struct packed {
      logic [7:0] feat_cur;
      logic [7:0] feat_prev;
      logic [7:0] count_cur;
      logic [7:0] lba_lo_cur;
      logic [7:0] lba_lo_prev;
      logic [7:0] lba_mid_cur;
      logic [7:0] lba_mid_prev;
      logic [7:0] lba_hi_cur;
      logic [7:0] lba_hi_prev;
      logic [7:0] dev_head;
      logic [7:0] command;
   } qlwc_tf_s;

   // Decoded log-write request
   typedef struct packed {
      logic [4:0]  tag;
      logic [15:0] count;
      logic [47:0] addr;
   } qlwc_req_s;

   // Completion report from the log engine
   typedef struct packed {
      logic [4:0] tag;
      logic       crc;
      logic       unc;
      logic       idn;
      logic       abt;
   } qlwc_done_s;

   // Frame kinds sent to the host
   typedef enum logic [1:0] {
      QLWC_FR_SDB = 2'h1,
      QLWC_FR_D2H = 2'h2
   } qlwc_frame_e;

   typedef enum logic [2:0] {
      QLWC_ST_IDLE = 3'b001,
      QLWC_ST_SDB  = 3'b010,
      QLWC_ST_D2H  = 3'b100
   } qlwc_state_e;

endpackage : qlwc_pkg

// file: verif/qlwc_host.sv
`timescale 1ns/1ps
`default_nettype none
module qlwc_host
   import qlwc_pkg::*;
(
   // Taskfile side
   input  wire logic clk_sys,
   input  wire logic tf_ready,
   output logic      tf_valid,
   output qlwc_tf_s  tf,
   // Frame side
   input  wire logic fr_valid,
   input  wire logic slow,
   output logic      fr_ready
);
   int wcnt = 0;

   initial begin
      tf_valid = 1'b0;
      tf = '0;
      fr_ready = 1'b0;
   end

   task automatic issue(input qlwc_tf_s t);
      @(posedge clk_sys) #2;
      while (!tf_ready) @(posedge clk_sys) #2;
      tf_valid = 1'b1;
      tf = t;
      @(posedge clk_sys) #2;
      tf_valid = 1'b0;
      tf = ~t;
   endtask : issue

   always @(posedge clk_sys) begin
      #2;
      if (fr_valid && !fr_ready) begin
         wcnt = wcnt + 1;
         fr_ready = !slow || wcnt > 3;
      end else begin
         fr_ready = 1'b0;
         wcnt = 0;
      end
   end
endmodule : qlwc_host
`default_nettype wire

// file: verif/test_queued_log_write_cmd.sv
`timescale 1ns/1ps
`default_nettype none
module test_queued_log_write_cmd
   import qlwc_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        arst_n = 1'b0;
   logic        done_valid = 1'b0;
   logic        slow = 1'b0;
   logic        tf_valid, tf_ready, req_valid, fr_valid, fr_ready;
   logic [31:0] fr_act;
   logic [4:0]  fr_tag;
   logic [7:0]  ef, sf;
   qlwc_tf_s    tf;
   qlwc_req_s   req;
   qlwc_done_s  done = '0;
   qlwc_frame_e fr_kind;
   qlwc_req_s   rq[$];
   logic [38:0] fq[$];
   int          failures = 0;
   int          num_checks = 0;
   int          cyc = 0;

   qlwc_cmd uut (.clk_sys, .arst_n, .tf_valid, .tf, .tf_ready, .req_valid, .req,
      .done_valid, .done, .fr_valid, .fr_kind, .fr_act, .fr_tag, .fr_ready,
      .command_error_flags(ef), .command_status_flags(sf));
   qlwc_host host (.clk_sys, .tf_ready, .tf_valid, .tf, .fr_valid, .slow, .fr_ready);

   always #12.5 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      cyc++;
      if (req_valid) rq.push_back(req);
      if (fr_valid && fr_ready) fq.push_back({fr_kind, fr_act, fr_tag});
      if (cyc == 5000) begin
         failures++;
         end_sim();
      end
   end

   task automatic chk(input logic [63:0] s, e, input string m);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk

   task automatic end_sim();
      if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   function automatic qlwc_tf_s mk(logic [7:0] op, fc, dh, logic [4:0] tg);
      return {fc, 8'h5c, tg, 3'h5, 8'h11, 8'h44, 8'h22, 8'h55, 8'h33, 8'h66, dh, op};
   endfunction : mk

   task automatic dn(input qlwc_done_s d);
      @(posedge clk_sys) #2;
      done_valid = 1'b1;
      done = d;
      @(posedge clk_sys) #2;
      done_valid = 1'b0;
      done = ~d;
   endtask : dn

   task automatic wfr(input int n);
      for (int i = 0; i < 40 && fq.size() < n; i++) @(posedge clk_sys);
      #2;
   endtask : wfr

   task automatic t_accept();
      int n;
      logic [4:0] tg;
      for (int i = 0; i < 2; i++) begin
         n = rq.size();
         tg = i ? 5'h1f : 5'h00;
         host.issue(mk(8'h64, 8'ha2, i ? 8'hef : 8'h40, tg));
         repeat (2) @(posedge clk_sys);
         #2;
         chk(rq.size(), n + 1, "no request");
         chk(rq[n].tag, tg, "tag");
         chk(rq[n].count, 16'h5ca2, "count");
         chk(rq[n].addr, 48'h665544332211, "address");
         chk(ef, 8'h00, "error flags");
         chk(sf, 8'h40, "status");
      end
   endtask : t_accept

   task automatic t_reject();
      int n, f;
      for (int k = 0; k < 19; k++) begin
         if (k == 2) continue;
         n = rq.size();
         f = fq.size();
         slow = k[0];
         host.issue(k < 16 ? mk(8'h64, 8'(k), 8'h40, 5'h07) : mk(k == 16 ? 8'h65 : 8'h64,
            8'h02, k == 16 ? 8'h40 : k == 17 ? 8'h00 : 8'h50, 5'h07));
         wfr(f + 1);
         chk(fq[f][38:37], QLWC_FR_D2H, "kind");
         chk(fq[f][4:0], 5'h07, "tag");
         chk(ef, 8'h04, "abort");
         chk(sf, 8'h41, "status");
         chk(rq.size(), n, "stray request");
      end
      slow = 1'b0;
   endtask : t_reject

   task automatic t_sdb();
      int f;
      logic [31:0] acc;
      f = fq.size();
      acc = '0;
      slow = 1'b1;
      dn({5'h00, 4'h0});
      dn({5'h1f, 4'h0});
      dn({5'h0a, 4'h0});
      repeat (30) @(posedge clk_sys);
      #2;
      foreach (fq[i]) if (i >= f) acc |= fq[i][36:5];
      foreach (fq[i]) if (i >= f) chk(fq[i][38:37], QLWC_FR_SDB, "kind");
      chk(acc, 32'h8000_0401, "act bits");
      chk(ef, 8'h00, "error flags");
      chk(sf, 8'h40, "status");
      slow = 1'b0;
   endtask : t_sdb

   task automatic t_reset();
      int f;
      f = fq.size();
      dn({5'h03, 4'h0});
      arst_n = 1'b0;
      @(posedge clk_sys) #2;
      chk({tf_ready, req_valid, fr_valid}, 3'b100, "handshakes in reset");
      chk({ef, sf}, 16'h0000, "flags in reset");
      arst_n = 1'b1;
      @(posedge clk_sys) #2;
      chk(sf, 8'h40, "status after reset");
      repeat (4) @(posedge clk_sys);
      #2;
      chk(fq.size(), f, "frame after reset");
   endtask : t_reset

   task automatic t_err();
      int f;
      logic [7:0] ex[4] = '{8'h80, 8'h40, 8'h10, 8'h04};
      for (int i = 0; i < 4; i++) begin
         f = fq.size();
         dn({5'h09, 4'b1000 >> i});
         chk(tf_ready, 1'b0, "taskfile open while reporting");
         wfr(f + 1);
         chk(tf_ready, 1'b1, "taskfile closed after frame");
         chk(fq[f][38:37], QLWC_FR_D2H, "kind");
         chk(fq[f][4:0], 5'h09, "tag");
         chk(ef, ex[i], "error flags");
         chk(sf, 8'h41, "status");
      end
   endtask : t_err

   initial begin
      repeat (12) @(posedge clk_sys);
      #2;
      chk(sf, QLWC_ST_RST, "reset status");
      chk(ef, QLWC_ERR_RST, "reset error flags");
      chk({tf_ready, req_valid, fr_valid}, 3'b100, "reset handshakes");
      arst_n = 1'b1;
      t_accept();
      t_reject();
      t_sdb();
      t_reset();
      t_err();
      end_sim();
   end
endmodule : test_queued_log_write_cmd
`default_nettype wire
